// [src/dmah_map.svh]
`ifndef DMAH_MAP_SVH
`define DMAH_MAP_SVH

// ----------------------------------------
// controller register offsets (software side)
// ----------------------------------------
`define DMAH_REG_CMD 12'h000
`define DMAH_REG_CFG 12'h004
`define DMAH_REG_STATUS 12'h008
`define DMAH_REG_IRQ_STAT 12'h00c
`define DMAH_REG_IRQ_MASK 12'h010

// ----------------------------------------
// controller field layout and reset values
// ----------------------------------------
`define DMAH_CMD_W 6
`define DMAH_CFG_WAIT_LSB 0
`define DMAH_CFG_USED_LSB 8
`define DMAH_CFG_RESET 32'h0000_0077
`define DMAH_EVT_W 3
`define DMAH_EVT_DONE 0
`define DMAH_EVT_TC_SEEN 1
`define DMAH_EVT_REFUSED 2

// ----------------------------------------
// device register map
// ----------------------------------------
`define DMAH_DEV_SWC_ADDR 32'h0000_0000
`define DMAH_DEV_CHC_BASE 32'h0000_0100
`define DMAH_DEV_CNT_BASE 32'h0000_0200
`define DMAH_SWC_RESET 8'h77
`define DMAH_CHC_EN 32'h0000_0001
`define DMAH_CHC_INIT 32'h0000_0002
`define DMAH_CHC_SWTRIG 32'h0000_0004
`define DMAH_CHC_EN_BIT 0
`define DMAH_CHC_TC_BIT 7

`endif

// [src/dmah_pkg.sv]
package dmah_pkg;

  typedef enum logic [2:0] {
    OP_SWC = 3'b000,
    OP_POLL = 3'b001,
    OP_IRQ = 3'b010,
    OP_TRIG = 3'b011,
    OP_TERM = 3'b100
  } dmah_op_t;

  typedef struct packed {
    logic ram;
    logic [2:0] op;
    logic [1:0] ch;
  } dmah_cmd_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
  } dmah_apb_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SWC = 4'b0001,
    ST_POLL = 4'b0010,
    ST_POLL_X = 4'b0011,
    ST_IRQ_RD = 4'b0100,
    ST_TRG_CNT = 4'b0101,
    ST_TRG_WR = 4'b0110,
    ST_TRG_POLL = 4'b0111,
    ST_T_SAVE = 4'b1000,
    ST_T_CLR = 4'b1001,
    ST_T_INIT = 4'b1010,
    ST_T_TC = 4'b1011,
    ST_T_WB = 4'b1100,
    ST_T_EI = 4'b1101,
    ST_DONE = 4'b1110
  } dmah_state_t;

endpackage

// [src/dmah_apb_master.sv]
`timescale 1ns/1ps

module dmah_apb_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input dmah_pkg::dmah_apb_req_t req,
  output logic done,
  output logic [31:0] rdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);

  // ----------------------------------------
  // one transfer at a time; start is ignored while busy
  // ----------------------------------------
  wire logic take = !psel && start;
  wire logic ends = psel && penable && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 32'h0000_0000;
      pwdata <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
      done <= 1'b0;
    end else begin
      done <= ends;
      if (take) begin
        psel <= 1'b1;
        paddr <= req.addr;
        pwrite <= req.write;
        pwdata <= req.wdata;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (ends) begin
        psel <= 1'b0;
        penable <= 1'b0;
        rdata <= prdata;
      end
    end
  end

endmodule

// [src/dmah_apb_slave.sv]
`timescale 1ns/1ps
`include "dmah_map.svh"

module dmah_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic cmd_go,
  output dmah_pkg::dmah_cmd_t cmd,
  output logic [31:0] cfg,
  input wire logic [31:0] status,
  input wire logic [`DMAH_EVT_W-1:0] evt
);

  logic [`DMAH_EVT_W-1:0] stat_q, mask_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic setup = psel && !penable;
  wire logic acc = psel && penable && pready;
  wire logic hit_cmd = paddr == `DMAH_REG_CMD;
  wire logic hit_cfg = paddr == `DMAH_REG_CFG;
  wire logic hit_sts = paddr == `DMAH_REG_STATUS;
  wire logic hit_ist = paddr == `DMAH_REG_IRQ_STAT;
  wire logic hit_msk = paddr == `DMAH_REG_IRQ_MASK;
  wire logic hit = hit_cmd | hit_cfg | hit_sts | hit_ist | hit_msk;
  wire logic wr = acc && pwrite;
  wire logic [31:0] rd_mux = hit_cfg ? cfg :
    hit_sts ? status :
    hit_ist ? {29'h0000_0000, stat_q} :
    hit_msk ? {29'h0000_0000, mask_q} : 32'h0000_0000;
  // a new event beats a write-one-to-clear in the same cycle
  wire logic [`DMAH_EVT_W-1:0] clr = (wr && hit_ist) ? pwdata[`DMAH_EVT_W-1:0] : 3'h0;
  wire logic [`DMAH_EVT_W-1:0] stat_d = (stat_q & ~clr) | evt;

  // ----------------------------------------
  // registers; zero wait states, pready in the first access cycle
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      cfg <= `DMAH_CFG_RESET;
      mask_q <= 3'h0;
      stat_q <= 3'h0;
      cmd_go <= 1'b0;
      cmd <= '0;
      irq <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      prdata <= setup && !pwrite ? rd_mux : 32'h0000_0000;
      stat_q <= stat_d;
      irq <= |(stat_q & mask_q);
      cmd_go <= wr && hit_cmd;
      if (wr && hit_cmd) begin
        cmd <= pwdata[`DMAH_CMD_W-1:0];
      end
      if (wr && hit_cfg) begin
        cfg <= {20'h0_0000, pwdata[11:0]};
      end
      if (wr && hit_msk) begin
        mask_q <= pwdata[`DMAH_EVT_W-1:0];
      end
    end
  end

endmodule

// [src/dmah_ctrl.sv]
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "dmah_map.svh"

module dmah_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic mask_interrupts,
  output logic m_psel,
  output logic m_penable,
  output logic m_pwrite,
  output logic [31:0] m_paddr,
  output logic [31:0] m_pwdata,
  input wire logic [31:0] m_prdata,
  input wire logic m_pready
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] ctl_addr(input logic [1:0] ch);
    return `DMAH_DEV_CHC_BASE + {28'h000_0000, ch, 2'b00};
  endfunction

  function automatic logic [31:0] cnt_addr(input logic [1:0] ch);
    return `DMAH_DEV_CNT_BASE + {28'h000_0000, ch, 2'b00};
  endfunction

  function automatic logic [1:0] hi_ch(input logic [3:0] m);
    logic [1:0] r;
    r = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  dmah_pkg::dmah_state_t state_q;
  dmah_pkg::dmah_cmd_t cmd;
  dmah_pkg::dmah_apb_req_t req;
  logic cmd_go;
  logic [31:0] cfg;
  logic [31:0] status;
  logic [`DMAH_EVT_W-1:0] evt_q;
  logic [2:0] op_q;
  logic [1:0] ch_q;
  logic ram_q;
  logic [2:0] idx_q;
  logic [1:0] rep_q;
  logic pend_q;
  logic swc_done_q;
  logic [3:0] saved_q;
  logic [3:0] tcseen_q;
  logic [31:0] cnt_q;
  logic mdone;
  logic [31:0] mrdata;

  // ----------------------------------------
  // software-side registers
  // ----------------------------------------
  dmah_apb_slave u_slave (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .cmd_go(cmd_go),
    .cmd(cmd),
    .cfg(cfg),
    .status(status),
    .evt(evt_q)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic [7:0] cfg_wait = cfg[`DMAH_CFG_WAIT_LSB +: 8];
  wire logic [3:0] cfg_used = cfg[`DMAH_CFG_USED_LSB +: 4];
  wire logic [3:0] tgt_oh = 4'h1 << ch_q;
  wire logic [3:0] used_all = cfg_used | tgt_oh;
  wire logic [3:0] others = used_all & ~tgt_oh;
  wire logic [1:0] last_ch = hi_ch(used_all);
  wire logic [1:0] last_rep = ram_q ? 2'd2 : 2'd1;
  wire logic iter_st = state_q inside {dmah_pkg::ST_T_SAVE, dmah_pkg::ST_T_CLR, dmah_pkg::ST_T_TC,
                                       dmah_pkg::ST_T_WB};
  wire logic [3:0] iter_mask = (state_q == dmah_pkg::ST_T_CLR) ? used_all : others;
  wire logic [1:0] cur_ch = iter_st ? idx_q[1:0] : ch_q;
  wire logic iter_end = idx_q[2];
  wire logic iter_skip = !iter_end && !iter_mask[idx_q[1:0]];
  wire logic bus_st = iter_st ? (!iter_end && iter_mask[idx_q[1:0]]) :
    !(state_q inside {dmah_pkg::ST_IDLE, dmah_pkg::ST_T_EI, dmah_pkg::ST_DONE});
  wire logic start = bus_st && !pend_q;
  wire logic rd_tc = mrdata[`DMAH_CHC_TC_BIT];
  wire logic rd_en = mrdata[`DMAH_CHC_EN_BIT];
  wire logic op_bad = !(cmd.op inside {dmah_pkg::OP_SWC, dmah_pkg::OP_POLL, dmah_pkg::OP_IRQ,
                                       dmah_pkg::OP_TRIG, dmah_pkg::OP_TERM});
  // the reset wait value is known to misbehave, so it is never sent
  wire logic swc_bad = cmd.op == dmah_pkg::OP_SWC && cfg_wait == `DMAH_SWC_RESET;
  wire logic need_swc = cmd.op != dmah_pkg::OP_SWC && !swc_done_q;
  wire logic refuse = cmd_go && (state_q != dmah_pkg::ST_IDLE || op_bad || swc_bad || need_swc);
  wire logic last_clr = idx_q[1:0] == last_ch;

  assign status = {cnt_q[15:0], 4'h0, tcseen_q, saved_q, 2'b00, swc_done_q,
                   state_q != dmah_pkg::ST_IDLE};

  // ----------------------------------------
  // request to the device
  // ----------------------------------------
  wire logic req_wr = state_q inside {dmah_pkg::ST_SWC, dmah_pkg::ST_TRG_WR, dmah_pkg::ST_T_CLR,
                                      dmah_pkg::ST_T_INIT, dmah_pkg::ST_T_WB};
  wire logic [31:0] req_addr = state_q == dmah_pkg::ST_SWC ? `DMAH_DEV_SWC_ADDR :
    state_q inside {dmah_pkg::ST_TRG_CNT, dmah_pkg::ST_TRG_POLL} ? cnt_addr(cur_ch) : ctl_addr(cur_ch);
  logic [31:0] req_wdata;
  always_comb begin
    unique case (state_q)
      dmah_pkg::ST_SWC: req_wdata = {24'h00_0000, cfg_wait};
      dmah_pkg::ST_TRG_WR: req_wdata = `DMAH_CHC_EN | `DMAH_CHC_SWTRIG;
      dmah_pkg::ST_T_INIT: req_wdata = `DMAH_CHC_INIT;
      dmah_pkg::ST_T_WB: req_wdata = saved_q[idx_q[1:0]] ? `DMAH_CHC_EN : 32'h0000_0000;
      default: req_wdata = 32'h0000_0000;
    endcase
  end
  // one driver for the whole request word
  assign req = {req_addr, req_wr, req_wdata};

  dmah_apb_master u_master (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .req(req),
    .done(mdone),
    .rdata(mrdata),
    .psel(m_psel),
    .penable(m_penable),
    .pwrite(m_pwrite),
    .paddr(m_paddr),
    .pwdata(m_pwdata),
    .prdata(m_prdata),
    .pready(m_pready)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (start) begin
      pend_q <= 1'b1;
    end else if (mdone) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dmah_pkg::ST_IDLE;
      op_q <= 3'h0;
      ch_q <= 2'd0;
      ram_q <= 1'b0;
      idx_q <= 3'd0;
      rep_q <= 2'd0;
      swc_done_q <= 1'b0;
      saved_q <= 4'h0;
      tcseen_q <= 4'h0;
      cnt_q <= 32'h0000_0000;
      mask_interrupts <= 1'b0;
      evt_q <= 3'h0;
    end else begin
      evt_q <= {refuse, 1'b0, state_q == dmah_pkg::ST_DONE};
      idx_q <= iter_skip ? idx_q + 3'd1 : idx_q;
      unique case (state_q)
        dmah_pkg::ST_IDLE: begin
          idx_q <= 3'd0;
          rep_q <= 2'd0;
          if (cmd_go && !refuse) begin
            op_q <= cmd.op;
            ch_q <= cmd.ch;
            ram_q <= cmd.ram;
            unique case (cmd.op)
              dmah_pkg::OP_SWC: state_q <= dmah_pkg::ST_SWC;
              dmah_pkg::OP_POLL: state_q <= dmah_pkg::ST_POLL;
              dmah_pkg::OP_IRQ: state_q <= dmah_pkg::ST_IRQ_RD;
              // one trigger in flight at a time keeps requests spaced
              dmah_pkg::OP_TRIG: state_q <= dmah_pkg::ST_TRG_CNT;
              default: begin
                mask_interrupts <= 1'b1;
                saved_q <= 4'h0;
                state_q <= dmah_pkg::ST_T_SAVE;
              end
            endcase
          end
        end
        dmah_pkg::ST_SWC: begin
          if (mdone) begin
            swc_done_q <= 1'b1;
            state_q <= dmah_pkg::ST_DONE;
          end
        end
        dmah_pkg::ST_POLL: begin
          if (mdone && rd_tc) begin
            tcseen_q[ch_q] <= 1'b1;
            evt_q[`DMAH_EVT_TC_SEEN] <= 1'b1;
            state_q <= dmah_pkg::ST_POLL_X;
          end
        end
        dmah_pkg::ST_POLL_X: begin
          // one read may fail to clear the flag, so three follow
          if (mdone) begin
            rep_q <= rep_q + 2'd1;
            if (rep_q == 2'd2) begin
              state_q <= dmah_pkg::ST_DONE;
            end
          end
        end
        dmah_pkg::ST_IRQ_RD: begin
          if (mdone) begin
            rep_q <= rep_q + 2'd1;
            if (rd_tc) begin
              tcseen_q[ch_q] <= 1'b1;
            end
            if (rep_q == 2'd2) begin
              state_q <= dmah_pkg::ST_DONE;
            end
          end
        end
        dmah_pkg::ST_TRG_CNT: begin
          if (mdone) begin
            cnt_q <= mrdata;
            state_q <= dmah_pkg::ST_TRG_WR;
          end
        end
        dmah_pkg::ST_TRG_WR: begin
          if (mdone) begin
            state_q <= dmah_pkg::ST_TRG_POLL;
          end
        end
        dmah_pkg::ST_TRG_POLL: begin
          if (mdone && mrdata != cnt_q) begin
            cnt_q <= mrdata;
            state_q <= dmah_pkg::ST_DONE;
          end
        end
        dmah_pkg::ST_T_SAVE: begin
          if (iter_end) begin
            idx_q <= 3'd0;
            state_q <= dmah_pkg::ST_T_CLR;
          end else if (mdone) begin
            saved_q[idx_q[1:0]] <= rd_en;
            idx_q <= idx_q + 3'd1;
          end
        end
        dmah_pkg::ST_T_CLR: begin
          // stopping every used channel and the target first, the initialise bit alone is unreliable
          if (iter_end) begin
            idx_q <= 3'd0;
            state_q <= dmah_pkg::ST_T_INIT;
          end else if (mdone) begin
            if (last_clr && rep_q != last_rep) begin
              rep_q <= rep_q + 2'd1;
            end else begin
              rep_q <= 2'd0;
              idx_q <= idx_q + 3'd1;
            end
          end
        end
        dmah_pkg::ST_T_INIT: begin
          if (mdone) begin
            idx_q <= 3'd0;
            state_q <= dmah_pkg::ST_T_TC;
          end
        end
        dmah_pkg::ST_T_TC: begin
          // these reads consume the survivors' completion flags
          if (iter_end) begin
            idx_q <= 3'd0;
            state_q <= dmah_pkg::ST_T_WB;
          end else if (mdone) begin
            if (rd_tc && saved_q[idx_q[1:0]]) begin
              saved_q[idx_q[1:0]] <= 1'b0;
            end
            idx_q <= idx_q + 3'd1;
          end
        end
        dmah_pkg::ST_T_WB: begin
          if (iter_end) begin
            state_q <= dmah_pkg::ST_T_EI;
          end else if (mdone) begin
            idx_q <= idx_q + 3'd1;
          end
        end
        dmah_pkg::ST_T_EI: begin
          mask_interrupts <= 1'b0;
          state_q <= dmah_pkg::ST_DONE;
        end
        dmah_pkg::ST_DONE: begin
          state_q <= dmah_pkg::ST_IDLE;
        end
        default: begin
          state_q <= dmah_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

// [testbench/dmah_ctrl_asserts.sv]
`timescale 1ns/1ps
module dmah_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic mask_interrupts,
  input wire logic m_psel,
  input wire logic m_penable,
  input wire logic m_pwrite,
  input wire logic [31:0] m_paddr,
  input wire logic [31:0] m_pwdata,
  input wire logic [31:0] m_prdata,
  input wire logic m_pready
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h010 |=> pslverr)
    else $error("unmapped access not flagged");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_dev_hold: assert property (m_psel && !(m_penable && m_pready) |=> m_psel && $stable(m_paddr)
    && $stable(m_pwrite) && $stable(m_pwdata)) else $error("device request changed early");
  a_dev_setup: assert property ($rose(m_psel) |-> !m_penable ##1 m_penable)
    else $error("device setup phase wrong");
  a_dev_gap: assert property (m_penable && m_pready |=> !m_psel && !m_penable)
    else $error("device request not released");
  a_wait_not_reset: assert property (m_psel && m_pwrite && m_paddr == 32'h0000_0000
    |-> m_pwdata[7:0] != 8'h77) else $error("wait setting left at reset value");
  a_clear_masked: assert property (m_psel && m_pwrite && m_paddr[11:8] == 4'h1
    && m_pwdata == 32'h0000_0000 |-> mask_interrupts) else $error("enable cleared unmasked");
  a_init_masked: assert property (m_psel && m_pwrite && m_paddr[11:8] == 4'h1
    && m_pwdata == 32'h0000_0002 |-> mask_interrupts) else $error("initialise unmasked");
  a_unmask_idle: assert property ($fell(mask_interrupts) |-> !m_psel)
    else $error("unmask during device access");
endmodule
bind dmah_ctrl dmah_ctrl_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .irq, .mask_interrupts, .m_psel, .m_penable, .m_pwrite, .m_paddr,
  .m_pwdata, .m_prdata, .m_pready);

// [testbench/dmah_dev_model.sv]
`timescale 1ns/1ps
module dmah_dev_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  input wire logic [1:0] slow
);
  logic [7:0] swc_q;
  logic [31:0] ctl_q [4];
  logic [15:0] cnt_q [4];
  logic [2:0] tmr_q [4];
  logic [3:0] req_q, miss_q;
  logic [1:0] wt_q;
  logic [31:0] rd;
  wire acc = psel && penable;
  wire [1:0] ch = paddr[3:2];
  wire is_ctl = paddr[11:8] == 4'h1;
  wire is_cnt = paddr[11:8] == 4'h2;
  assign pready = acc && wt_q == slow;
  assign rd = is_ctl ? ctl_q[ch] : is_cnt ? {16'h0000, cnt_q[ch]} : {24'h00_0000, swc_q};
  // idle bus never repeats the last value
  assign prdata = pready ? rd : ~rd;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swc_q <= 8'h77;
      wt_q <= 2'h0;
      req_q <= 4'h0;
      miss_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        ctl_q[i] <= 32'h0000_0000;
        cnt_q[i] <= 16'h0010;
        tmr_q[i] <= 3'h0;
      end
    end else begin
      wt_q <= (acc && !pready) ? wt_q + 2'h1 : 2'h0;
      for (int i = 0; i < 4; i++) begin
        tmr_q[i] <= tmr_q[i] + 3'h1;
        if (req_q[i] && tmr_q[i] == 3'h7) begin
          req_q[i] <= 1'b0;
          cnt_q[i] <= cnt_q[i] - 16'h0001;
          ctl_q[i][7] <= 1'b1;
          miss_q[i] <= 1'b1;
        end
      end
      if (pready && pwrite && paddr == 32'h0000_0000) swc_q <= pwdata[7:0];
      if (pready && pwrite && is_ctl) begin
        if (pwdata[1]) begin
          ctl_q[ch] <= 32'h0000_0000;
          req_q[ch] <= 1'b0;
        end else begin
          ctl_q[ch][0] <= pwdata[0];
          // a request while one is pending is dropped; wrong wait setting never starts
          if (pwdata[2] && pwdata[0] && !req_q[ch] && swc_q != 8'h77) begin
            req_q[ch] <= 1'b1;
            tmr_q[ch] <= 3'h0;
          end
        end
      end
      // first read after completion misses the clear
      if (pready && !pwrite && is_ctl) begin
        if (miss_q[ch]) miss_q[ch] <= 1'b0;
        else ctl_q[ch][7] <= 1'b0;
      end
    end
  end
endmodule

// [testbench/dmah_ctrl_tb_top.sv]
`timescale 1ns/1ps
module dmah_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, mask_interrupts, e, ir;
  logic m_psel, m_penable, m_pwrite, m_pready, init_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, m_paddr, m_pwdata, m_prdata, r, st;
  logic [1:0] slow;
  logic [15:0] old;
  logic seen[4];
  int err_count, check_count, cyc;
  int n_rd[4], n_aft[4], n_clr[4];
  dmah_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .mask_interrupts, .m_psel, .m_penable, .m_pwrite, .m_paddr, .m_pwdata,
    .m_prdata, .m_pready);
  dmah_dev_model dev (.pclk, .presetn, .psel(m_psel), .penable(m_penable), .pwrite(m_pwrite),
    .paddr(m_paddr), .pwdata(m_pwdata), .prdata(m_prdata), .pready(m_pready), .slow);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // --------------------------------
  // device bus log
  // --------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (m_psel && m_penable && m_pready && m_paddr[11:8] == 4'h1) begin
      if (!m_pwrite) begin
        n_rd[m_paddr[3:2]]++;
        if (seen[m_paddr[3:2]]) n_aft[m_paddr[3:2]]++;
        if (m_prdata[7]) seen[m_paddr[3:2]] = 1'b1;
      end else if (m_pwdata == 32'h0000_0000 && !init_q) n_clr[m_paddr[3:2]]++;
      else if (m_pwdata == 32'h0000_0002) init_q = 1'b1;
    end
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (x !== g) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mk(input logic ram, input logic [2:0] op, input logic [1:0] ch);
    return {26'h000_0000, ram, op, ch};
  endfunction
  // waits for done or refusal (completion-seen comes earlier), keeps irq level, clears all events
  task automatic cmd(input logic [31:0] c);
    int i;
    apb(1'b1, 12'h000, c);
    i = 0;
    do begin
      apb(1'b0, 12'h00c, 32'h0);
      i++;
    end while (r[0] !== 1'b1 && r[2] !== 1'b1 && i < 100);
    st = r;
    ir = irq;
    apb(1'b1, 12'h00c, 32'h0000_0007);
  endtask
  task automatic clr_log;
    foreach (n_rd[i]) begin
      n_rd[i] = 0;
      n_aft[i] = 0;
      n_clr[i] = 0;
      seen[i] = 1'b0;
    end
    init_q = 1'b0;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs;
    apb(1'b0, 12'h004, 32'h0);
    chk("cfg reset", 32'h0000_0077, r);
    apb(1'b0, 12'h010, 32'h0);
    chk("mask reset", 32'h0, r);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", 32'h1, e);
    $display("test regs done");
  endtask
  task automatic t_refuse;
    apb(1'b1, 12'h010, 32'h0000_0004);
    cmd(mk(1'b0, dmah_pkg::OP_SWC, 2'h0));
    chk("swc refused", 32'h4, st);
    chk("irq refused", 32'h1, ir);
    chk("wait kept", 32'h77, dev.swc_q);
    apb(1'b1, 12'h010, 32'h0);
    cmd(mk(1'b0, dmah_pkg::OP_POLL, 2'h0));
    chk("poll refused", 32'h4, st);
    chk("irq masked", 32'h0, ir);
    $display("test refuse done");
  endtask
  task automatic t_swc;
    apb(1'b1, 12'h004, 32'h0000_0312);
    cmd(mk(1'b0, dmah_pkg::OP_SWC, 2'h0));
    chk("swc done", 32'h1, st);
    chk("wait value", 32'h12, dev.swc_q);
    apb(1'b0, 12'h008, 32'h0);
    chk("wait flag", 32'h1, r[1]);
    $display("test swc done");
  endtask
  task automatic t_trig(input logic [1:0] ch);
    old = dev.cnt_q[ch] - 16'h0001;
    cmd(mk(1'b0, dmah_pkg::OP_TRIG, ch));
    chk("trig done", 32'h1, st);
    chk("count", old, dev.cnt_q[ch]);
    chk("tc set", 32'h1, dev.ctl_q[ch][7]);
    apb(1'b0, 12'h008, 32'h0);
    chk("status count", old, r[31:16]);
    $display("test trig done");
  endtask
  task automatic t_poll;
    clr_log();
    cmd(mk(1'b0, dmah_pkg::OP_POLL, 2'h0));
    chk("poll done", 32'h3, st);
    chk("reads after tc", 32'h3, n_aft[0]);
    chk("tc cleared", 32'h0, dev.ctl_q[0][7]);
    $display("test poll done");
  endtask
  task automatic t_isr;
    t_trig(2'h1);
    clr_log();
    cmd(mk(1'b0, dmah_pkg::OP_IRQ, 2'h1));
    chk("isr done", 32'h1, st);
    chk("isr reads", 32'h3, n_rd[1]);
    chk("isr tc cleared", 32'h0, dev.ctl_q[1][7]);
    $display("test isr done");
  endtask
  task automatic t_term;
    t_trig(2'h1);
    clr_log();
    apb(1'b1, 12'h010, 32'h0000_0001);
    cmd(mk(1'b1, dmah_pkg::OP_TERM, 2'h2));
    chk("term done", 32'h1, st);
    chk("done irq", 32'h1, ir);
    chk("clears ch0", 32'h1, n_clr[0]);
    chk("clears ch1", 32'h1, n_clr[1]);
    chk("clears last", 32'h3, n_clr[2]);
    chk("init sent", 32'h1, init_q);
    chk("ch0 restored", 32'h1, dev.ctl_q[0][0]);
    chk("ch1 dropped", 32'h0, dev.ctl_q[1][0]);
    chk("ch1 tc read", 32'h0, dev.ctl_q[1][7]);
    chk("target idle", 32'h0, dev.req_q[2]);
    $display("test term done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
    {err_count, check_count, cyc} = '0;
    clr_log();
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_refuse();
    t_swc();
    slow <= 2'h1;
    t_trig(2'h0);
    t_poll();
    t_isr();
    slow <= 2'h2;
    t_term();
    give_verdict();
  end
endmodule
